// *** shared/ssx_defines.vh ***
// constants for the subtract, swap and xor execution datapath
`ifndef SSX_DEFINES_VH
`define SSX_DEFINES_VH
`define SSX_OP_W 3
`define SSX_OP_SUB 3'h0
`define SSX_OP_SUBB 3'h1
`define SSX_OP_SWAP 3'h2
`define SSX_OP_XORL 3'h3
`define SSX_OP_XORF 3'h4
`define SSX_OP_LOAD_DIRECTION_REGISTER 3'h5
`define SSX_LOAD_DIRECTION_REGISTER_A 3'h5
`define SSX_LOAD_DIRECTION_REGISTER_B 3'h6
`define SSX_LOAD_DIRECTION_REGISTER_C 3'h7
`define SSX_ACC_RST 8'h00
`define SSX_DIR_RST 8'hFF
`define SSX_FLAG_RST 1'b0
`define SSX_DEST_ACC 1'b0
`define SSX_FILE_ADDR_MAX 7'h7F
`endif

// *** hw/ssx_dir_bank.v ***
// three port direction registers loaded from the accumulator
`timescale 1ns/10ps
`include "ssx_defines.vh"
module ssx_dir_bank (
  input wire ref_clk,
  input wire rst_b,
  input wire load,
  input wire [2:0] sel,
  input wire [7:0] wdata,
  output reg [7:0] port_a_direction,
  output reg [7:0] port_b_direction,
  output reg [7:0] port_c_direction
);
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      port_a_direction <= `SSX_DIR_RST;
      port_b_direction <= `SSX_DIR_RST;
      port_c_direction <= `SSX_DIR_RST;
    end else if (load) begin
      // operands outside 5..7 load nothing
      case (sel)
        `SSX_LOAD_DIRECTION_REGISTER_A: port_a_direction <= wdata;
        `SSX_LOAD_DIRECTION_REGISTER_B: port_b_direction <= wdata;
        `SSX_LOAD_DIRECTION_REGISTER_C: port_c_direction <= wdata;
        default: begin
        end
      endcase
    end
  end
endmodule

// *** hw/ssx_alu.v ***
// execution datapath for subtract, nibble exchange, xor and direction load
// Behaviour
// - file minus accumulator, to acc or file
// - file minus acc minus inverted carry
// - swap file nibbles, flags untouched
// - xor acc with literal, zero flag only
// - load direction register 5/6/7 from acc
// - xor acc with file, zero flag only
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`include "ssx_defines.vh"
module ssx_alu (
  input wire ref_clk,
  input wire rst_b,
  input wire op_valid,
  input wire [2:0] op_code,
  input wire dest_sel,
  input wire [6:0] file_addr,
  input wire [7:0] file_rdata,
  input wire [7:0] literal,
  input wire carry_in,
  output reg file_we,
  output reg [6:0] file_waddr,
  output reg [7:0] file_wdata,
  output reg [7:0] acc,
  output reg carry_flag,
  output reg digit_carry_flag,
  output reg zero_flag,
  output wire [7:0] port_a_direction,
  output wire [7:0] port_b_direction,
  output wire [7:0] port_c_direction
);
  // nine-bit subtract: bit 8 set means no borrow
  function [8:0] sub9;
    input [7:0] a;
    input [7:0] b;
    input cin;
    begin
      sub9 = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
    end
  endfunction
  function [4:0] sub5;
    input [3:0] a;
    input [3:0] b;
    input cin;
    begin
      sub5 = {1'b0, a} + {1'b0, ~b} + {4'h0, cin};
    end
  endfunction

  reg [7:0] result;
  reg has_result;
  reg set_z;
  reg set_cdc;
  reg next_c;
  reg next_dc;
  reg [8:0] diff;
  reg [4:0] ldiff;
  reg borrow_in;
  wire load_direction_register_load;

  // carry comes from the status register outside, so flag writes use carry_in
  always @* begin
    result = 8'h00;
    has_result = 1'b0;
    set_z = 1'b0;
    set_cdc = 1'b0;
    borrow_in = (op_code == `SSX_OP_SUBB) ? carry_in : 1'b1;
    diff = sub9(file_rdata, acc, borrow_in);
    ldiff = sub5(file_rdata[3:0], acc[3:0], borrow_in);
    next_c = diff[8];
    next_dc = ldiff[4];
    case (op_code)
      `SSX_OP_SUB, `SSX_OP_SUBB: begin
        result = diff[7:0];
        has_result = 1'b1;
        set_z = 1'b1;
        set_cdc = 1'b1;
      end
      `SSX_OP_SWAP: begin
        result = {file_rdata[3:0], file_rdata[7:4]};
        has_result = 1'b1;
      end
      `SSX_OP_XORL: begin
        result = acc ^ literal;
        has_result = 1'b1;
        set_z = 1'b1;
      end
      `SSX_OP_XORF: begin
        result = acc ^ file_rdata;
        has_result = 1'b1;
        set_z = 1'b1;
      end
      default: begin
      end
    endcase
  end

  assign load_direction_register_load = op_valid && (op_code == `SSX_OP_LOAD_DIRECTION_REGISTER);

  always @(posedge ref_clk) begin
    if (!rst_b) begin
      acc <= `SSX_ACC_RST;
      carry_flag <= `SSX_FLAG_RST;
      digit_carry_flag <= `SSX_FLAG_RST;
      zero_flag <= `SSX_FLAG_RST;
      file_we <= 1'b0;
      file_waddr <= 7'h00;
      file_wdata <= 8'h00;
    end else begin
      file_we <= 1'b0;
      if (op_valid && has_result) begin
        // literal xor always lands in the accumulator
        if (dest_sel == `SSX_DEST_ACC || op_code == `SSX_OP_XORL) begin
          acc <= result;
        end else begin
          file_we <= 1'b1;
          file_waddr <= file_addr;
          file_wdata <= result;
        end
        if (set_z)
          zero_flag <= (result == 8'h00);
        if (set_cdc) begin
          carry_flag <= next_c;
          digit_carry_flag <= next_dc;
        end else begin
          carry_flag <= carry_in;
        end
      end else begin
        carry_flag <= carry_in;
      end
    end
  end

  ssx_dir_bank u_dir (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .load(load_direction_register_load),
    .sel(file_addr[2:0]),
    .wdata(acc),
    .port_a_direction(port_a_direction),
    .port_b_direction(port_b_direction),
    .port_c_direction(port_c_direction)
  );
endmodule

// *** verif/ssx_alu_monitor.sv ***
// assertion checker for the execution datapath
`timescale 1ns/10ps
module ssx_mon(
  input ref_clk, rst_b, op_valid, dest_sel, carry_in, file_we,
  input carry_flag, digit_carry_flag, zero_flag,
  input [2:0] op_code,
  input [7:0] file_rdata, file_wdata, acc, literal
);
  // operands as they stood at the edge that took the op
  logic [7:0] w, f;
  logic [7:0] k;
  logic b;
  always @(posedge ref_clk) begin
    w <= acc;
    k <= literal;
    f <= file_rdata;
    b <= !carry_in;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_sub;
    op_valid && op_code == 0 && dest_sel |=> file_we && file_wdata == f - w;
  endproperty
  a_sub: assert property (p_sub) else $error("sub to file");
  property p_subb;
    op_valid && op_code == 1 && !dest_sel |=> acc == f - w - b;
  endproperty
  a_subb: assert property (p_subb) else $error("sub borrow");
  property p_swap;
    op_valid && op_code == 2 && !dest_sel |=> acc == {f[3:0], f[7:4]} && $stable(zero_flag);
  endproperty
  a_swap: assert property (p_swap) else $error("swap");
  // literal xor lands in the accumulator whatever the destination bit says
  property p_xorl;
    op_valid && op_code == 3 |=> acc == (w ^ k) && !file_we && zero_flag == (acc == 0);
  endproperty
  a_xorl: assert property (p_xorl) else $error("xor literal");
  property p_xorf;
    op_valid && op_code == 4 && !dest_sel |=> acc == (w ^ f) && zero_flag == (acc == 0);
  endproperty
  a_xorf: assert property (p_xorf) else $error("xor file");
  property p_flags;
    op_valid && op_code == 0 |=> carry_flag == (w <= f) && zero_flag == (f == w);
  endproperty
  a_flags: assert property (p_flags) else $error("sub flags");
endmodule
bind ssx_alu ssx_mon i_ssx_mon(.*);

// *** verif/ssx_file_model.sv ***
// file register model behind the datapath
`timescale 1ns/10ps
module ssx_file_model(
  input ref_clk, file_we,
  input [6:0] file_addr, file_waddr,
  input [7:0] file_wdata,
  output [7:0] file_rdata
);
  // each location starts out holding its own address
  logic [7:0] mem [128];
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i);
  assign file_rdata = mem[file_addr];
  always @(posedge ref_clk) if (file_we) mem[file_waddr] <= file_wdata;
endmodule

// *** verif/tb.sv ***
// self-checking bench for the execution datapath
`timescale 1ns/10ps
module tb;
  logic ref_clk = 0, rst_b = 0, op_valid = 0, dest_sel = 0, carry_in = 0;
  logic [2:0] op_code = 0;
  logic [6:0] file_addr = 0;
  logic [7:0] literal = 0;
  wire [7:0] file_rdata, file_wdata, acc, pa, pb, pc;
  wire [6:0] file_waddr;
  wire file_we, carry_flag, digit_carry_flag, zero_flag;
  int fails = 0, tests_run = 0, cyc = 0;
  always #2.5 ref_clk = ~ref_clk;
  ssx_alu i_ssx_alu(.*, .port_a_direction(pa), .port_b_direction(pb), .port_c_direction(pc));
  ssx_file_model i_ssx_file_model(.*);
  always @(posedge ref_clk) if (++cyc > 500) begin
    fails++;
    print_verdict;
  end
  task print_verdict;
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input [23:0] g, e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  // a gap cycle between ops keeps op_valid to one assignment per step
  task run(input [2:0] c, input d, input [6:0] a, input [7:0] k);
    @(posedge ref_clk);
    {op_code, dest_sel, file_addr, literal, op_valid} <= {c, d, a, k, 1'b1};
    @(posedge ref_clk);
    op_valid <= 0;
    #1;
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_b <= 1;
    run(3, 1, 0, 8'h5a);
    chk({acc, file_we, zero_flag}, {8'h5a, 2'b00});
    run(3, 0, 0, 8'h59);
    run(0, 1, 7'h10, 0);
    chk({file_we, file_waddr, file_wdata, carry_flag, digit_carry_flag, zero_flag},
        {1'b1, 7'h10, 8'h0d, 3'b100});
    run(0, 0, 7'h03, 0);
    chk({acc, carry_flag, digit_carry_flag, zero_flag}, {8'h00, 3'b111});
    run(2, 0, 7'h25, 0);
    chk({acc, digit_carry_flag, zero_flag}, {8'h52, 2'b11});
    run(2, 1, 7'h25, 0);
    chk({file_wdata, acc}, 16'h5252);
    run(4, 1, 7'h52, 0);
    chk({file_wdata, file_we, zero_flag, acc}, {8'h00, 2'b11, 8'h52});
    run(4, 0, 7'h0f, 0);
    chk({acc, zero_flag}, {8'h5d, 1'b0});
    run(1, 0, 7'h70, 0);
    chk({acc, carry_flag, digit_carry_flag, zero_flag}, {8'h12, 3'b100});
    carry_in <= 1;
    run(1, 0, 7'h12, 0);
    chk({acc, carry_flag, digit_carry_flag, zero_flag}, {8'h00, 3'b111});
    run(3, 0, 0, 8'ha5);
    run(5, 0, 7'h04, 0);
    run(5, 0, 7'h05, 0);
    chk({pa, pb, pc}, 24'ha5_ffff);
    run(5, 0, 7'h06, 0);
    run(5, 0, 7'h07, 0);
    chk({pb, pc}, 16'ha5a5);
    print_verdict;
  end
endmodule
